// ---- design/stepper_cfg_pkg.sv ----
// Constants shared by the stepper slave setup logic and its hold timer.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Behaviour
// - Break-contact halt by default; steps need ground.
// - Active halt stops steps on both axes.
// - Setting flips halt/limit sense to make-contact.
// - Node address 1..F from switch; zero forbidden.
// - Address switch sampled only at power-on.
// - Rate code 0010 10 Mbps, 0011 20 Mbps.
// - Rate switch sampled only at power-on.
// - Step pulse gives drive current, timeout gives hold.
// - Steady pulses keep drive current on.
// - Switch selects hold time; first option 150 ms.
// - Expansion port supports exactly one unit.
package stepper_cfg_pkg;
    // ***************************************
    // Timing.
    // ***************************************
    localparam int CLK_HZ           = 25_000_000;
    localparam int HOLD_FIRST_MS    = 150;
    localparam int HOLD_SECOND_MS   = 50;
    localparam int HOLD_FIRST_CYC   = HOLD_FIRST_MS * (CLK_HZ / 1000);
    localparam int HOLD_SECOND_CYC  = HOLD_SECOND_MS * (CLK_HZ / 1000);
    localparam int TIMER_W          = 22;
    // ***************************************
    // Register map and fields.
    // ***************************************
    localparam int         ADDR_W        = 4;
    localparam logic [3:0] CTRL_OFS      = 4'h0;
    localparam logic [3:0] STATUS_OFS    = 4'h4;
    localparam int         CTRL_MAKE_BIT = 0;
    localparam int         CTRL_EXP_BIT  = 1;
    localparam int         CTRL_UNIT_LSB = 2;
    localparam int         CTRL_UNIT_W   = 3;
    localparam logic [4:0] CTRL_RESET    = 5'h00;
    localparam int         ST_RATE_LSB   = 4;
    localparam int         ST_ADDR_FLT   = 8;
    localparam int         ST_RATE_FLT   = 9;
    localparam int         ST_SW_FLT     = 10;
    localparam int         ST_HALT       = 11;
    localparam int         ST_DRIVE_X    = 12;
    localparam int         ST_DRIVE_Y    = 13;
    localparam int         ST_HOLD_SEL   = 14;
    localparam int         ST_CFG_DONE   = 15;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // ***************************************
    // Switch codes.
    // ***************************************
    localparam logic [3:0] ADDR_FORBIDDEN = 4'h0;
    localparam logic [3:0] RATE_10M       = 4'h2;
    localparam logic [3:0] RATE_20M       = 4'h3;
    localparam logic [2:0] EXP_UNIT_ONLY  = 3'h0;
    typedef enum logic [1:0] {REG_CTRL, REG_STATUS, REG_NONE} reg_sel_t;
endpackage : stepper_cfg_pkg

// ---- design/hold_timer.sv ----
// Drive/hold current timer for one motor axis.
// Assumes trigger is a one-cycle pulse per step actually sent to the motor.
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
    parameter int FIRST_CYC  = stepper_cfg_pkg::HOLD_FIRST_CYC,
    parameter int SECOND_CYC = stepper_cfg_pkg::HOLD_SECOND_CYC
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Control.
    input  wire logic trigger,
    input  wire logic holdSelect,
    // Current level, high for drive.
    output var  logic driveOn
);
    localparam int W = stepper_cfg_pkg::TIMER_W;
    localparam logic [W-1:0] FIRST_LOAD  = W'(FIRST_CYC - 1);
    localparam logic [W-1:0] SECOND_LOAD = W'(SECOND_CYC - 1);

    logic [W-1:0] count_reg, count_next;
    logic         drive_reg, drive_next;

    always_comb begin
        count_next = count_reg;
        drive_next = drive_reg;
        if (trigger) begin
            drive_next = 1'b1;
            count_next = holdSelect ? SECOND_LOAD : FIRST_LOAD;
        end else if (count_reg != '0) begin
            count_next = count_reg - W'(1);
        end else begin
            drive_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_reg <= '0;
            drive_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            drive_reg <= drive_next;
        end
    end

    assign driveOn = drive_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_step_drives: assert property (trigger |=> driveOn)
        else $error("Drive current not raised by step.");
    a_drive_kept: assert property (driveOn && count_reg != '0 |=> driveOn)
        else $error("Drive current dropped before hold time.");
    a_first_option: assert property (trigger && !holdSelect |=> count_reg == FIRST_LOAD)
        else $error("First hold option not loaded.");
    a_timer_restart: assert property (
        driveOn && trigger |=> count_reg == (holdSelect ? SECOND_LOAD : FIRST_LOAD))
        else $error("Hold timer not restarted by step.");
    a_hold_return: assert property (driveOn && count_reg == '0 && !trigger |=> !driveOn)
        else $error("Hold current not restored after timeout.");
endmodule : hold_timer
`default_nettype wire

// ---- design/stepper_slave_setup_and_hold_timer.sv ----
// Setup and safety logic of a two-axis stepper slave: power-on switch
// capture, halt and limit gating of step pulses, drive/hold timers and an
// AXI4-Lite register slave. Assumes all pins synchronous to ref_clk.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stepper_slave_setup_and_hold_timer #(
    parameter int HOLD_FIRST_CYC  = stepper_cfg_pkg::HOLD_FIRST_CYC,
    parameter int HOLD_SECOND_CYC = stepper_cfg_pkg::HOLD_SECOND_CYC
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite write channels.
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // Setup switches.
    input  wire logic [3:0]  nodeAddressSwitch,
    input  wire logic [3:0]  bitRateSwitch,
    input  wire logic        holdSwitchTimeSelect,
    input  wire logic        motorTypeSwitch,
    input  wire logic        pulseInputStyleSwitch,
    // Safety inputs, high while the contact is open.
    input  wire logic        emergencyHaltIn,
    input  wire logic [1:0]  limitX,
    input  wire logic [1:0]  limitY,
    // Step pulses from the pulse generator.
    input  wire logic        stepInX,
    input  wire logic        stepInY,
    // Motor side.
    output var  logic        stepOutX,
    output var  logic        stepOutY,
    output var  logic        driveCurrentX,
    output var  logic        driveCurrentY,
    // Link setup.
    output var  logic [3:0]  nodeAddress,
    output var  logic        linkRate20,
    output var  logic        configValid,
    output var  logic        expansionEnable
);
    // ***************************************
    // Power-on switch capture.
    // ***************************************
    typedef enum {CFG_WAIT, CFG_RUN} cfg_state_t;
    cfg_state_t cfgState_reg, cfgState_next;
    logic [3:0] addr_reg, addr_next;
    logic [3:0] rate_reg, rate_next;
    logic       holdSel_reg, holdSel_next;
    logic       swFault_reg, swFault_next;

    // Switches are read once, on the first edge after reset; later moves
    // are ignored so a bumped switch cannot re-address a running node.
    always_comb begin
        cfgState_next = cfgState_reg;
        addr_next     = addr_reg;
        rate_next     = rate_reg;
        holdSel_next  = holdSel_reg;
        swFault_next  = swFault_reg;
        unique case (cfgState_reg)
            CFG_WAIT: begin
                addr_next     = nodeAddressSwitch;
                rate_next     = bitRateSwitch;
                holdSel_next  = holdSwitchTimeSelect;
                swFault_next  = motorTypeSwitch | pulseInputStyleSwitch;
                cfgState_next = CFG_RUN;
            end
            CFG_RUN: begin
                cfgState_next = CFG_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfgState_reg <= CFG_WAIT;
            addr_reg     <= 4'h0;
            rate_reg     <= 4'h0;
            holdSel_reg  <= 1'b0;
            swFault_reg  <= 1'b0;
        end else begin
            cfgState_reg <= cfgState_next;
            addr_reg     <= addr_next;
            rate_reg     <= rate_next;
            holdSel_reg  <= holdSel_next;
            swFault_reg  <= swFault_next;
        end
    end

    logic cfgRun, addrFault, rateFault, cfgOk;
    assign cfgRun    = (cfgState_reg == CFG_RUN);
    assign addrFault = (addr_reg == stepper_cfg_pkg::ADDR_FORBIDDEN);
    assign rateFault = (rate_reg != stepper_cfg_pkg::RATE_10M) &&
                       (rate_reg != stepper_cfg_pkg::RATE_20M);
    assign cfgOk     = cfgRun && !addrFault && !rateFault && !swFault_reg;

    // ***************************************
    // Control register.
    // ***************************************
    logic [4:0] ctrl_reg, ctrl_next;
    logic       makeSense;
    assign makeSense = ctrl_reg[stepper_cfg_pkg::CTRL_MAKE_BIT];

    // ***************************************
    // Halt and limit gating.
    // ***************************************
    function automatic logic inputActive(input logic pinOpen, input logic make);
        inputActive = make ? !pinOpen : pinOpen;
    endfunction : inputActive

    logic haltNow, limitHitX, limitHitY;
    assign haltNow   = inputActive(emergencyHaltIn, makeSense);
    assign limitHitX = inputActive(limitX[0], makeSense) | inputActive(limitX[1], makeSense);
    assign limitHitY = inputActive(limitY[0], makeSense) | inputActive(limitY[1], makeSense);

    logic stepX_reg, stepX_next, stepY_reg, stepY_next, halt_reg;
    logic cfgValid_reg, rate20_reg, expEn_reg;

    always_comb begin
        // One halt term gates both axes in the same cycle.
        stepX_next = stepInX && cfgOk && !haltNow && !limitHitX;
        stepY_next = stepInY && cfgOk && !haltNow && !limitHitY;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stepX_reg    <= 1'b0;
            stepY_reg    <= 1'b0;
            halt_reg     <= 1'b0;
            cfgValid_reg <= 1'b0;
            rate20_reg   <= 1'b0;
            expEn_reg    <= 1'b0;
        end else begin
            stepX_reg    <= stepX_next;
            stepY_reg    <= stepY_next;
            halt_reg     <= haltNow;
            cfgValid_reg <= cfgOk;
            // Taken from the captured code's next value so the rate output
            // settles on the same edge as the code itself and never moves later.
            rate20_reg   <= (rate_next == stepper_cfg_pkg::RATE_20M);
            expEn_reg    <= ctrl_reg[stepper_cfg_pkg::CTRL_EXP_BIT];
        end
    end

    // ***************************************
    // Drive/hold timers.
    // ***************************************
    logic driveX, driveY;
    hold_timer #(.FIRST_CYC(HOLD_FIRST_CYC), .SECOND_CYC(HOLD_SECOND_CYC)) timerX (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .trigger    (stepX_next),
        .holdSelect (holdSel_reg),
        .driveOn    (driveX)
    );
    hold_timer #(.FIRST_CYC(HOLD_FIRST_CYC), .SECOND_CYC(HOLD_SECOND_CYC)) timerY (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .trigger    (stepY_next),
        .holdSelect (holdSel_reg),
        .driveOn    (driveY)
    );

    // ***************************************
    // AXI4-Lite slave.
    // ***************************************
    function automatic stepper_cfg_pkg::reg_sel_t decodeReg(input logic [3:0] a);
        if (a == stepper_cfg_pkg::CTRL_OFS)        decodeReg = stepper_cfg_pkg::REG_CTRL;
        else if (a == stepper_cfg_pkg::STATUS_OFS) decodeReg = stepper_cfg_pkg::REG_STATUS;
        else                                       decodeReg = stepper_cfg_pkg::REG_NONE;
    endfunction : decodeReg

    logic        awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
    logic [3:0]  awAddr_reg, awAddr_next;
    logic [31:0] wData_reg, wData_next, rdata_reg, rdata_next, statusWord;
    logic        wLane0_reg, wLane0_next;
    logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic        awready_reg, wready_reg, arready_reg;
    logic [2:0]  unitReq;

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[3:0] = addr_reg;
        statusWord[stepper_cfg_pkg::ST_RATE_LSB +: 4] = rate_reg;
        statusWord[stepper_cfg_pkg::ST_ADDR_FLT] = addrFault;
        statusWord[stepper_cfg_pkg::ST_RATE_FLT] = rateFault;
        statusWord[stepper_cfg_pkg::ST_SW_FLT]   = swFault_reg;
        statusWord[stepper_cfg_pkg::ST_HALT]     = halt_reg;
        statusWord[stepper_cfg_pkg::ST_DRIVE_X]  = driveX;
        statusWord[stepper_cfg_pkg::ST_DRIVE_Y]  = driveY;
        statusWord[stepper_cfg_pkg::ST_HOLD_SEL] = holdSel_reg;
        statusWord[stepper_cfg_pkg::ST_CFG_DONE] = cfgRun;
    end

    assign unitReq = wData_reg[stepper_cfg_pkg::CTRL_UNIT_LSB +: stepper_cfg_pkg::CTRL_UNIT_W];

    always_comb begin
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next  = wHeld_reg;
        wData_next  = wData_reg;
        wLane0_next = wLane0_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        ctrl_next   = ctrl_reg;
        if (awvalid && awready_reg) begin
            awHeld_next = 1'b1;
            awAddr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            wHeld_next  = 1'b1;
            wData_next  = wdata;
            wLane0_next = wstrb[0];
        end
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (awHeld_reg && wHeld_reg && !bvalid_reg) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = stepper_cfg_pkg::RESP_SLVERR;
            if (decodeReg(awAddr_reg) == stepper_cfg_pkg::REG_CTRL) begin
                // Only one expansion unit exists; naming another is refused.
                if (wLane0_reg && unitReq != stepper_cfg_pkg::EXP_UNIT_ONLY) begin
                    bresp_next = stepper_cfg_pkg::RESP_SLVERR;
                end else begin
                    bresp_next = stepper_cfg_pkg::RESP_OKAY;
                    if (wLane0_reg) begin
                        ctrl_next = wData_reg[4:0];
                    end
                end
            end
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = stepper_cfg_pkg::RESP_OKAY;
            unique case (decodeReg(araddr))
                stepper_cfg_pkg::REG_CTRL:   rdata_next = {27'h0, ctrl_reg};
                stepper_cfg_pkg::REG_STATUS: rdata_next = statusWord;
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = stepper_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_reg  <= 1'b0;
            awAddr_reg  <= 4'h0;
            wHeld_reg   <= 1'b0;
            wData_reg   <= 32'h0000_0000;
            wLane0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            ctrl_reg    <= stepper_cfg_pkg::CTRL_RESET;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= 2'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end else begin
            awHeld_reg  <= awHeld_next;
            awAddr_reg  <= awAddr_next;
            wHeld_reg   <= wHeld_next;
            wData_reg   <= wData_next;
            wLane0_reg  <= wLane0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            ctrl_reg    <= ctrl_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            awready_reg <= !awHeld_next && !bvalid_next;
            wready_reg  <= !wHeld_next && !bvalid_next;
            arready_reg <= !rvalid_next;
        end
    end

    // ***************************************
    // Outputs.
    // ***************************************
    assign awready         = awready_reg;
    assign wready          = wready_reg;
    assign bvalid          = bvalid_reg;
    assign bresp           = bresp_reg;
    assign arready         = arready_reg;
    assign rvalid          = rvalid_reg;
    assign rdata           = rdata_reg;
    assign rresp           = rresp_reg;
    assign stepOutX        = stepX_reg;
    assign stepOutY        = stepY_reg;
    assign driveCurrentX   = driveX;
    assign driveCurrentY   = driveY;
    assign nodeAddress     = addr_reg;
    assign linkRate20      = rate20_reg;
    assign configValid     = cfgValid_reg;
    assign expansionEnable = expEn_reg;

    // ***************************************
    // Assertions.
    // ***************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence ctrlWriteUnitBad;
        awHeld_reg && wHeld_reg && !bvalid_reg && wLane0_reg &&
        decodeReg(awAddr_reg) == stepper_cfg_pkg::REG_CTRL && unitReq != 3'h0;
    endsequence
    sequence refusedAnswer;
        bvalid_reg && bresp_reg == stepper_cfg_pkg::RESP_SLVERR && $stable(ctrl_reg);
    endsequence

    a_halt_both_axes: assert property (haltNow |=> !stepOutX && !stepOutY)
        else $error("Step pulse passed during halt.");
    a_break_default: assert property (
        !makeSense && emergencyHaltIn |=> !stepOutX && !stepOutY)
        else $error("Step pulse with open halt contact.");
    a_make_sense: assert property (
        makeSense && !emergencyHaltIn |=> !stepOutX && !stepOutY)
        else $error("Step pulse with closed make contact.");
    a_addr_forbidden: assert property (cfgRun && addrFault |=> !configValid && !stepOutX)
        else $error("Forbidden address accepted.");
    a_addr_frozen: assert property (cfgRun && $past(cfgRun) |-> $stable(nodeAddress))
        else $error("Node address changed after power-on.");
    a_rate_code: assert property (configValid |-> rate_reg[3:1] == 3'h1)
        else $error("Running with a forbidden rate code.");
    a_rate_frozen: assert property (cfgRun ##1 cfgRun |-> $stable(rate_reg) && $stable(linkRate20))
        else $error("Rate setting changed after power-on.");
    a_exp_single: assert property (ctrlWriteUnitBad |=> refusedAnswer)
        else $error("Second expansion unit accepted.");
endmodule : stepper_slave_setup_and_hold_timer
`default_nettype wire

// ---- verification/step_source.sv ----
// Partner model: the pulse generator that feeds step pulses to the slave.
// Assumes the bench raises fire for one cycle per wanted step.
`timescale 1ns/1ps
`default_nettype none
module step_source (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Requests in, pulses out.
    input  wire logic [1:0] fire,
    output var  logic [1:0] step
);
    logic [1:0] pulse_reg;
    // A registered pulse delays each step by one cycle; its width is that of fire.
    always_ff @(posedge ref_clk) begin
        pulse_reg <= rst ? 2'h0 : fire;
    end
    assign step = pulse_reg;
endmodule : step_source
`default_nettype wire

// ---- verification/stepper_slave_setup_and_hold_timer_tb.sv ----
// Self-checking bench for the stepper slave setup and hold timer block.
// Assumes hold counts are shortened by parameter to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module stepper_slave_setup_and_hold_timer_tb;
    localparam int NF = 20;
    localparam int NS = 8;
    logic ref_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, holdSwitchTimeSelect = 1'b0, emergencyHaltIn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, nodeAddressSwitch = 4'h5, bitRateSwitch = 4'h3;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] limitX = 2'h0, limitY = 2'h0, fire = 2'h0, step, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, stepOutX, stepOutY, driveCurrentX, driveCurrentY;
    logic linkRate20, configValid, expansionEnable;
    logic motorTypeSwitch = 1'b0, pulseInputStyleSwitch = 1'b0;
    logic [3:0] nodeAddress;
    int errors = 0;
    int n_checks = 0;
    always #20 ref_clk = ~ref_clk;
    step_source u_src (.ref_clk, .rst, .fire, .step);
    stepper_slave_setup_and_hold_timer #(.HOLD_FIRST_CYC(NF), .HOLD_SECOND_CYC(NS)) u_dut (
        .ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .nodeAddressSwitch, .bitRateSwitch, .holdSwitchTimeSelect, .motorTypeSwitch,
        .pulseInputStyleSwitch, .emergencyHaltIn, .limitX, .limitY, .stepInX(step[0]),
        .stepInY(step[1]), .stepOutX, .stepOutY, .driveCurrentX, .driveCurrentY, .nodeAddress,
        .linkRate20, .configValid, .expansionEnable);
    // *****
    // Helpers.
    // *****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Handshakes are judged at the falling edge, half a cycle before the rising edge, so no race with the slave.
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta, tw, td;
        td = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 40 && !td; i++) begin
            @(negedge ref_clk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            td = bvalid === 1'b1;
            if (td) chk(bresp, er);
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (td) bready <= 1'b0;
        end
        if (!td) chk(32'h1, 32'h0);
    endtask : axw
    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ta, td;
        td = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 40 && !td; i++) begin
            @(negedge ref_clk);
            ta = arvalid && arready === 1'b1;
            td = rvalid === 1'b1;
            if (td) begin
                chk(rdata, ed);
                chk(rresp, er);
            end
            @(posedge ref_clk);
            if (ta) arvalid <= 1'b0;
            if (td) rready <= 1'b0;
        end
        if (!td) chk(32'h1, 32'h0);
    endtask : axr
    task automatic pulse(input logic [1:0] ax, input logic ex);
        @(posedge ref_clk);
        fire <= ax;
        @(posedge ref_clk);
        fire <= 2'h0;
        tick(1);
        chk({stepOutY, stepOutX, driveCurrentY, driveCurrentX} & {ax, ax}, ex ? {ax, ax} : 4'h0);
    endtask : pulse
    task automatic setup(input logic [3:0] a, input logic [3:0] r, input logic s);
        @(posedge ref_clk);
        nodeAddressSwitch <= a;
        bitRateSwitch <= r;
        holdSwitchTimeSelect <= s;
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        tick(3);
    endtask : setup
    task automatic t_halt;
        @(posedge ref_clk);
        emergencyHaltIn <= 1'b1;
        pulse(2'h3, 1'b0);
        @(posedge ref_clk);
        emergencyHaltIn <= 1'b0;
        pulse(2'h3, 1'b1);
        tick(NF + 4);
        $display("halt test done");
    endtask : t_halt
    task automatic t_pol;
        axw(4'h0, 32'h1, 2'h0);
        pulse(2'h3, 1'b0);
        @(posedge ref_clk);
        emergencyHaltIn <= 1'b1;
        limitX <= 2'h1;
        limitY <= 2'h3;
        pulse(2'h1, 1'b0);
        pulse(2'h2, 1'b1);
        axw(4'h0, 32'h0, 2'h0);
        @(posedge ref_clk);
        emergencyHaltIn <= 1'b0;
        limitX <= 2'h0;
        limitY <= 2'h0;
        tick(NF + 4);
        $display("polarity test done");
    endtask : t_pol
    task automatic t_hold(input int n);
        pulse(2'h1, 1'b1);
        tick(n / 2);
        pulse(2'h1, 1'b1);
        tick(n - 1);
        chk(driveCurrentX, 1'b1);
        tick(2);
        chk(driveCurrentX, 1'b0);
        $display("hold test done");
    endtask : t_hold
    task automatic t_axi;
        axw(4'h0, 32'h6, 2'h2);
        axr(4'h0, 32'h0, 2'h0);
        axr(4'h4, 32'h0000_8035, 2'h0);
        axw(4'h4, 32'h0, 2'h2);
        axw(4'h0, 32'h2, 2'h0);
        tick(2);
        chk(expansionEnable, 1'b1);
        axr(4'h8, 32'h0, 2'h2);
        axw(4'h0, 32'h0, 2'h0);
        $display("register test done");
    endtask : t_axi
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // *****
    // Sequence.
    // *****
    initial begin
        setup(4'h5, 4'h3, 1'b0);
        chk({configValid, linkRate20, nodeAddress}, 6'h35);
        chk(linkRate20, 1'b1);
        @(posedge ref_clk);
        nodeAddressSwitch <= 4'hA;
        bitRateSwitch <= 4'h2;
        tick(3);
        chk({configValid, linkRate20, nodeAddress}, 6'h35);
        t_halt();
        t_pol();
        t_hold(NF);
        t_axi();
        setup(4'hF, 4'h2, 1'b1);
        chk({configValid, linkRate20, nodeAddress}, 6'h2F);
        t_hold(NS);
        for (int r = 0; r < 4; r++) begin
            setup(4'h1, r[3:0], 1'b0);
            chk(configValid, r >= 2);
        end
        @(posedge ref_clk);
        motorTypeSwitch <= 1'b1;
        setup(4'h1, 4'h2, 1'b0);
        chk(configValid, 1'b0);
        @(posedge ref_clk);
        motorTypeSwitch <= 1'b0;
        pulseInputStyleSwitch <= 1'b1;
        setup(4'h1, 4'h2, 1'b0);
        chk(configValid, 1'b0);
        @(posedge ref_clk);
        pulseInputStyleSwitch <= 1'b0;
        setup(4'h0, 4'h2, 1'b0);
        pulse(2'h3, 1'b0);
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end
endmodule : stepper_slave_setup_and_hold_timer_tb
`default_nettype wire
